// [src/ecwm_pkg.sv]
// package for the eeprom config word mapper
// assumes: words arrive as 16-bit values tagged with their byte address
package ecwm_pkg;

   // ------------------------------------------------------------
   // eeprom word addresses handled here
   // ------------------------------------------------------------
   localparam logic [7:0] WORD_0C = 8'h0c;
   localparam logic [7:0] WORD_0E = 8'h0e;
   localparam logic [7:0] WORD_10 = 8'h10;
   localparam logic [7:0] WORD_12 = 8'h12;
   localparam logic [7:0] WORD_14 = 8'h14;

   // ------------------------------------------------------------
   // configuration offsets (per port)
   // ------------------------------------------------------------
   localparam logic [7:0] CFG_70 = 8'h70;
   localparam logic [7:0] CFG_74 = 8'h74;
   localparam logic [7:0] CFG_78 = 8'h78;
   localparam logic [7:0] CFG_7C = 8'h7c;
   localparam logic [7:0] CFG_8C = 8'h8c;
   localparam logic [7:0] CFG_94 = 8'h94;
   localparam logic [7:0] CFG_C4 = 8'hc4;
   localparam logic [7:0] CFG_CC = 8'hcc;
   localparam logic [7:0] CFG_E4 = 8'he4;

   // register indices inside the per-port image
   localparam int NUM_CFG = 9;
   localparam logic [3:0] IX_70 = 4'h0;
   localparam logic [3:0] IX_74 = 4'h1;
   localparam logic [3:0] IX_78 = 4'h2;
   localparam logic [3:0] IX_7C = 4'h3;
   localparam logic [3:0] IX_8C = 4'h4;
   localparam logic [3:0] IX_94 = 4'h5;
   localparam logic [3:0] IX_C4 = 4'h6;
   localparam logic [3:0] IX_CC = 4'h7;
   localparam logic [3:0] IX_E4 = 4'h8;

   // hardware default of every image register before load
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;

   // avalon register map: status and port select / read window
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_PORTSEL = 8'h04;
   localparam logic [9:0] REG_WINDOW = 10'h100;
   localparam logic [31:0] UNMAPPED_DATA = 32'hdead_beef;

   // read answer delay in cycles
   localparam int READ_LATENCY = 1;

   typedef enum logic [1:0] {ECWM_IDLE, ECWM_LOAD, ECWM_DONE} ecwm_state_e;

endpackage

// [src/ecwm_word_if.sv]
// interface carrying one loaded eeprom word into the port image
// assumes: single clock, source drives valid for one cycle per word
interface ecwm_word_if;
   logic        valid;
   logic [7:0]  addr;
   logic [15:0] data;
   modport src (output valid, output addr, output data);
   modport dst (input valid, input addr, input data);
endinterface

// [src/ecwm_port_image.sv]
// per-port configuration image for the loaded eeprom words
// assumes: one word per cycle on the word interface, synchronous reset
module ecwm_port_image #(
   parameter bit HAS_BW_NOTIFY = 1'b1
) (
   // clock and reset
   input wire logic         core_clk,
   input wire logic         reset,
   // loaded words
   ecwm_word_if.dst         word,
   // read side
   input wire logic [3:0]   rd_index,
   output logic     [31:0]  rd_data
);
   logic [31:0] cfg_reg [ecwm_pkg::NUM_CFG];

   // ------------------------------------------------------------
   // word to field mapping
   // ------------------------------------------------------------
   // each word only touches its own bits; untouched bits keep reset defaults [RL22]
   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < ecwm_pkg::NUM_CFG; i++) begin
            cfg_reg[i] <= ecwm_pkg::CFG_RESET;
         end
      end else if (word.valid) begin
         case (word.addr)
            ecwm_pkg::WORD_0C: begin
               cfg_reg[ecwm_pkg::IX_C4][1:0]   <= word.data[1:0];   // [RL1]
               cfg_reg[ecwm_pkg::IX_CC][11:10] <= word.data[3:2];   // [RL2]
               cfg_reg[ecwm_pkg::IX_C4][15]    <= word.data[4];     // [RL3]
               cfg_reg[ecwm_pkg::IX_70][14]    <= word.data[5];     // [RL4]
               cfg_reg[ecwm_pkg::IX_74][15]    <= word.data[6];     // [RL5]
               cfg_reg[ecwm_pkg::IX_70][13]    <= word.data[7];     // [RL6]
               cfg_reg[ecwm_pkg::IX_8C][5]     <= word.data[8];     // [RL7]
               if (HAS_BW_NOTIFY) begin
                  cfg_reg[ecwm_pkg::IX_CC][21] <= word.data[9];     // [RL8]
               end
               cfg_reg[ecwm_pkg::IX_8C][6]     <= word.data[10];    // [RL9]
               cfg_reg[ecwm_pkg::IX_8C][0]     <= word.data[11];    // [RL10]
               cfg_reg[ecwm_pkg::IX_CC][19]    <= word.data[12];    // [RL11]
               cfg_reg[ecwm_pkg::IX_8C][1]     <= word.data[13];    // [RL12]
               cfg_reg[ecwm_pkg::IX_E4][12]    <= word.data[14];    // [RL13]
               cfg_reg[ecwm_pkg::IX_8C][3]     <= word.data[15];    // [RL14]
            end
            ecwm_pkg::WORD_0E: begin
               cfg_reg[ecwm_pkg::IX_94][14:0]  <= word.data[14:0];  // [RL15]
               cfg_reg[ecwm_pkg::IX_E4][18]    <= word.data[15];    // [RL16]
            end
            ecwm_pkg::WORD_10: begin
               cfg_reg[ecwm_pkg::IX_74][30:16] <= word.data[14:0];  // [RL17]
               cfg_reg[ecwm_pkg::IX_8C][31]    <= word.data[15];    // [RL18]
            end
            ecwm_pkg::WORD_12: begin
               cfg_reg[ecwm_pkg::IX_78][30:16] <= word.data[14:0];  // [RL19]
               cfg_reg[ecwm_pkg::IX_8C][16]    <= word.data[15];    // [RL20]
            end
            ecwm_pkg::WORD_14: begin
               cfg_reg[ecwm_pkg::IX_7C][6:0]   <= word.data[6:0];   // [RL21]
            end
            default: begin
            end
         endcase
      end
   end

   // read mux; out of range reads as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      if (rd_index < 4'(ecwm_pkg::NUM_CFG)) begin
         rd_data = cfg_reg[rd_index];
      end
   end
endmodule // ecwm_port_image

// [src/ecwm_top.sv]
// eeprom config word mapper: applies words 0ch..14h to ports 0..2
// assumes: words delivered by an upstream eeprom reader, avalon-mm host reads the image
//
// Operation
// RL1: word 0ch bits 1:0 to c4h bits 1:0, ports 0-2.
// RL2: word 0ch bits 3:2 to cch bits 11:10, ports 0-2.
// RL3: word 0ch bit 4 to c4h bit 15, ports 0-2.
// RL4: word 0ch bit 5 to 70h bit 14, msi disable.
// RL5: word 0ch bit 6 to 74h bit 15, compliance parity disable.
// RL6: word 0ch bit 7 to 70h bit 13, power management disable.
// RL7: word 0ch bit 8 to 8ch bit 5, posted pass non-posted.
// RL8: word 0ch bit 9 to cch bit 21, ports 1 and 2 only.
// RL9: word 0ch bit 10 to 8ch bit 6, ordering freeze.
// RL10: word 0ch bit 11 to 8ch bit 0, zero shortens sof latency.
// RL11: word 0ch bit 12 to cch bit 19, surprise down.
// RL12: word 0ch bit 13 to 8ch bit 1, data select writable.
// RL13: word 0ch bit 14 to e4h bit 12, ltr enable.
// RL14: word 0ch bit 15 to 8ch bit 3, 4kb boundary check.
// RL15: word 0eh bits 14:0 to 94h bits 14:0, margin levels.
// RL16: word 0eh bit 15 to e4h bit 18, obff enable.
// RL17: word 10h bits 14:0 to 74h bits 30:16, nominal levels.
// RL18: word 10h bit 15 to 8ch bit 31, gen2 low deemph mode.
// RL19: word 12h bits 14:0 to 78h bits 30:16, post cursor.
// RL20: word 12h bit 15 to 8ch bit 16, phy control six bit 0.
// RL21: word 14h bits 6:0 to 7ch bits 6:0, latency and detect.
// RL22: host access waits until load is done; unloaded bits keep defaults.
module ecwm_top #(
   parameter int NUM_PORTS = 3
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // loaded eeprom words
   input  wire logic        load_start,
   input  wire logic        load_word_valid,
   input  wire logic [7:0]  load_word_addr,
   input  wire logic [15:0] load_word_data,
   input  wire logic        load_end,
   // avalon-mm slave
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // status
   output logic             load_done
);
   // ------------------------------------------------------------
   // load sequencing
   // ------------------------------------------------------------
   ecwm_pkg::ecwm_state_e state_reg;
   ecwm_word_if word_bus ();

   // idle until start, load words, done at end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= ecwm_pkg::ECWM_IDLE;
      end else begin
         case (state_reg)
            ecwm_pkg::ECWM_IDLE: if (load_start) state_reg <= ecwm_pkg::ECWM_LOAD;
            ecwm_pkg::ECWM_LOAD: if (load_end) state_reg <= ecwm_pkg::ECWM_DONE;
            ecwm_pkg::ECWM_DONE: if (load_start) state_reg <= ecwm_pkg::ECWM_LOAD;
            default: state_reg <= ecwm_pkg::ECWM_IDLE;
         endcase
      end
   end

   // words only accepted while loading
   assign word_bus.valid = load_word_valid && (state_reg == ecwm_pkg::ECWM_LOAD);
   assign word_bus.addr  = load_word_addr;
   assign word_bus.data  = load_word_data;
   assign load_done      = (state_reg == ecwm_pkg::ECWM_DONE);

   // ------------------------------------------------------------
   // port images
   // ------------------------------------------------------------
   logic [1:0]  portsel_reg;
   logic [31:0] img_data [NUM_PORTS];

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         // bandwidth notification exists only on downstream ports
         ecwm_port_image #(.HAS_BW_NOTIFY(p != 0)) u_img (  // [RL8]
            .core_clk (core_clk),
            .reset    (reset),
            .word     (word_bus),
            .rd_index (avs_address[5:2]),
            .rd_data  (img_data[p])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // avalon slave
   // ------------------------------------------------------------
   logic        ack_reg;
   logic        busy;
   logic [31:0] rdata_next;

   // host held off until load completes [RL22]
   assign busy = (state_reg != ecwm_pkg::ECWM_DONE);
   assign avs_waitrequest = (avs_read || avs_write) && (busy || !ack_reg);

   // one wait cycle per access gives registered read data
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read || avs_write) && !busy && !ack_reg;
      end
   end

   // port select register steers the read window
   always_ff @(posedge core_clk) begin
      if (reset) begin
         portsel_reg <= 2'h0;
      end else if (avs_write && !avs_waitrequest && avs_address == 10'(ecwm_pkg::REG_PORTSEL)
                   && avs_byteenable[0]) begin
         portsel_reg <= avs_writedata[1:0];
      end
   end

   // read decode
   always_comb begin
      rdata_next = ecwm_pkg::UNMAPPED_DATA;
      if (avs_address == 10'(ecwm_pkg::REG_STATUS)) begin
         rdata_next = {30'h0, state_reg == ecwm_pkg::ECWM_LOAD, load_done};
      end else if (avs_address == 10'(ecwm_pkg::REG_PORTSEL)) begin
         rdata_next = {30'h0, portsel_reg};
      end else if (avs_address[9:8] == 2'h1 && portsel_reg < 2'(NUM_PORTS)) begin
         rdata_next = img_data[portsel_reg];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !busy && !ack_reg) begin
         avs_readdata <= rdata_next;
      end
   end
endmodule // ecwm_top

// [tb/ecwm_top_props.sv]
// concurrent checks on the config word mapper top ports
// assumes: one clock domain, synchronous active-high reset
module ecwm_props #(
   parameter int NUM_PORTS = 3
) (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        reset,
   // load side
   input wire logic        load_start,
   input wire logic        load_end,
   input wire logic        load_done,
   // bus side
   input wire logic [9:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // load tracking
   // ---------------------------------------------
   logic loading_reg;
   // remembers an open load so a stray end pulse is not mistaken for one
   always_ff @(posedge core_clk) begin
      if (reset) loading_reg <= 1'b0;
      else if (load_start) loading_reg <= 1'b1;
      else if (load_end) loading_reg <= 1'b0;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_load_closed;
      loading_reg && load_end && !load_start;
   endsequence
   sequence s_read_taken;
      avs_read && !avs_waitrequest;
   endsequence
   chk_stall_unloaded: assert property ((avs_read || avs_write) && !load_done |-> avs_waitrequest)
      else $error("bus answered before load finished");
   chk_done_after_end: assert property (s_load_closed |=> load_done)
      else $error("load end did not raise done");
   chk_start_clears: assert property (load_start |=> !load_done)
      else $error("done stayed up across a reload");
   chk_done_holds: assert property (load_done && !load_start |=> load_done)
      else $error("done dropped without a reload");
   chk_answer_bound: assert property (load_done && (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
      else $error("access not answered within one wait cycle");
   chk_status_read: assert property (s_read_taken ##0 (avs_address == 10'h000) |-> avs_readdata == 32'h1)
      else $error("status read wrong after load");
   chk_unmapped_read: assert property (s_read_taken ##0 (avs_address == 10'h3fc) |-> avs_readdata == ecwm_pkg::UNMAPPED_DATA)
      else $error("unmapped read wrong");
   chk_readdata_holds: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without a read");
endmodule // ecwm_props
bind ecwm_top ecwm_props #(.NUM_PORTS(NUM_PORTS)) i_ecwm_props (.core_clk, .reset, .load_start, .load_end,
   .load_done, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest);

// [tb/ecwm_eeprom_model.sv]
// serial eeprom reader stand-in: streams words 0ch..16h into the mapper
// assumes: bench pulses go for one cycle; slow inserts a gap after each word
module ecwm_eeprom_model (
   // clock, reset, control
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        go,
   input wire logic        slow,
   input wire logic [15:0] words [0:4],
   output logic            busy,
   // word stream
   output logic            load_start,
   output logic            load_word_valid,
   output logic [7:0]      load_word_addr,
   output logic [15:0]     load_word_data,
   output logic            load_end
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {busy, load_start, load_word_valid, load_word_addr, load_word_data, load_end} = '0;
   // word 16h is sent too; the mapper must ignore it, so its data is all ones
   always begin
      @(posedge core_clk);
      if (go && !reset) begin
         busy <= 1'b1;
         load_start <= 1'b1;
         @(posedge core_clk);
         load_start <= 1'b0;
         for (int k = 0; k < 6; k++) begin
            load_word_valid <= 1'b1;
            load_word_addr <= 8'h0c + 8'(2 * k);
            load_word_data <= (k < 5) ? words[k] : 16'hffff;
            @(posedge core_clk);
            // idle data is inverted so a stale word never looks valid
            if (slow) begin
               load_word_valid <= 1'b0;
               load_word_data <= ~load_word_data;
               @(posedge core_clk);
            end
         end
         load_word_valid <= 1'b0;
         load_word_data <= ~load_word_data;
         load_end <= 1'b1;
         @(posedge core_clk);
         load_end <= 1'b0;
         busy <= 1'b0;
      end
   end
endmodule // ecwm_eeprom_model

// [tb/tb_top.sv]
// self-checking bench for the eeprom config word mapper
// assumes: eeprom model feeds the loader, bench is the avalon master
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, reset, go, slow, busy, load_start, load_word_valid, load_end, load_done;
   logic avs_read, avs_write, avs_waitrequest;
   logic [7:0] load_word_addr;
   logic [15:0] load_word_data;
   logic [15:0] wd [0:4];
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   int mismatches = 0, checked = 0;
   always #5 core_clk = ~core_clk;
   ecwm_eeprom_model i_ecwm_eeprom_model (.core_clk, .reset, .go, .slow, .words(wd), .busy, .load_start,
      .load_word_valid, .load_word_addr, .load_word_data, .load_end);
   ecwm_top #(.NUM_PORTS(3)) i_ecwm_top (.core_clk, .reset, .load_start, .load_word_valid, .load_word_addr,
      .load_word_data, .load_end, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .load_done);
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // request held until the rising edge that samples waitrequest low; data taken at that edge
   task automatic bus(input bit wr, input logic [9:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge core_clk);
      avs_address <= a; avs_writedata <= d; avs_read <= !wr; avs_write <= wr;
      do begin @(posedge core_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 3000);
      r = avs_readdata;
      if (n >= 3000) mismatches++;
      avs_read <= 1'b0; avs_write <= 1'b0;
   endtask
   task automatic do_load(input bit s);
      int n;
      n = 0;
      slow <= s; go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      do begin @(negedge core_clk); n++; end while ((busy !== 1'b0 || load_done !== 1'b1) && n < 200);
      if (n >= 200) mismatches++;
      @(posedge core_clk);
   endtask
   function automatic logic [31:0] expv(int p, int i);
      logic [15:0] a, e, g, h, f;
      {a, e, g, h, f} = {wd[0], wd[1], wd[2], wd[3], wd[4]};
      case (i)
         0: return {17'h0, a[5], a[7], 13'h0};
         1: return {1'b0, g[14:0], a[6], 15'h0};
         2: return {1'b0, h[14:0], 16'h0};
         3: return {25'h0, f[6:0]};
         4: return {g[15], 14'h0, h[15], 9'h0, a[10], a[8], 1'b0, a[15], 1'b0, a[13], a[11]};
         5: return {17'h0, e[14:0]};
         6: return {16'h0, a[4], 13'h0, a[1:0]};
         7: return {10'h0, a[9] & (p != 0), 1'b0, a[12], 7'h0, a[3:2], 10'h0};
         default: return {13'h0, e[15], 5'h0, a[14], 12'h0};
      endcase
   endfunction
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_stall;
      chk({31'h0, load_done}, 32'h0);
      fork
         bus(1'b0, 10'h000, 32'h0, q);
         do_load(1'b0);
      join
      chk(q, 32'h1);
   endtask
   // every port and image word is compared whole, so stray bits also show
   task automatic t_map(input bit s, input logic [15:0] w [0:4]);
      wd = w;
      do_load(s);
      for (int p = 0; p < 3; p++) begin
         bus(1'b1, 10'h004, 32'(p), q);
         for (int i = 0; i < 9; i++) begin
            bus(1'b0, 10'h100 + 10'(4 * i), 32'h0, q);
            chk(q, expv(p, i));
         end
      end
   endtask
   task automatic t_misc;
      bus(1'b1, 10'h004, 32'h3, q);
      bus(1'b0, 10'h100, 32'h0, q);
      chk(q, ecwm_pkg::UNMAPPED_DATA);
      bus(1'b1, 10'h3fc, 32'h0, q);
      bus(1'b0, 10'h004, 32'h0, q);
      chk(q, 32'h3);
      bus(1'b0, 10'h3fc, 32'h0, q);
      chk(q, ecwm_pkg::UNMAPPED_DATA);
   endtask
   initial begin
      core_clk = 0; reset = 1; go = 0; slow = 0; wd = '{default: 16'h0};
      avs_address = 0; avs_read = 0; avs_write = 0; avs_writedata = 0;
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      t_stall;
      t_map(1'b0, '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff});
      t_map(1'b1, '{16'ha5c3, 16'h5a3c, 16'h9669, 16'h6996, 16'h0ff0});
      t_misc;
      wrap_up;
   end
   // watchdog far beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      wrap_up;
   end
endmodule // tb_top
